// >>> tpg_in_filter.sv
/*
 Input conditioner for the timer input pin: three-stage synchroniser and a
 glitch filter that accepts a new level only after it has stood long enough.
 Assumes an asynchronous pin and one system clock.
*/
`timescale 1ns/1ps
module tpg_in_filter #(
  parameter int HOLD_CYC = 5
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Pin and filtered result
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  import tpg_pkg::*;

  localparam int CW = $clog2(HOLD_CYC + 1);

  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic level_q;
  logic level_d;
  logic rise_q;
  logic rise_d;
  logic fall_q;
  logic fall_d;
  logic agree;

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1 feeds stage 2 only; stages 2 and 3 must agree before counting
  assign agree = (sync_q[1] == sync_q[2]);

  always_comb begin
    sync_d = {sync_q[1:0], pin_i};
    cnt_d = cnt_q;
    level_d = level_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (!agree || sync_q[2] == level_q) begin
      cnt_d = '0;
    end else if (cnt_q == CW'(HOLD_CYC - 1)) begin
      // Level stood longer than the reject window
      cnt_d = '0;
      level_d = sync_q[2];
      rise_d = sync_q[2];
      fall_d = !sync_q[2];
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync_q <= 3'h0;
      cnt_q <= '0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      cnt_q <= cnt_d;
      level_q <= level_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign level_o = level_q;
  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule : tpg_in_filter

// >>> tpg_pkg.sv
/*
 Package for the pulse-generation timer: register offsets, field positions,
 reset values, mode and start encodings, timing figures.
 Assumes a 100 MHz system clock and an APB register slave.
*/
package tpg_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PERIOD_OFF = 8'h04;
  localparam logic [7:0] DUTY_OFF = 8'h08;
  localparam logic [7:0] COUNT_OFF = 8'h0c;
  localparam logic [7:0] STAT_OFF = 8'h10;

  // Control field positions
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int START_LSB = 3;
  localparam int START_W = 2;
  localparam int REPEAT_BIT = 5;
  localparam int PRESC_LSB = 6;
  localparam int PRESC_W = 2;
  localparam int LEVEL_BIT = 8;

  // Reset values
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] DUTY_RST = 16'hffff;

  // Operating modes (only timer and pulse generation act here)
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_PULSE = 3'h7;

  // Start selection codes
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_CMD = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] START_FALL = 2'h3;

  // Noise filter: pulses up to four main-clock periods are rejected
  localparam int CLK_PERIOD_NS = 10;
  localparam int MAIN_CLK_NS = 10;
  localparam int REJECT_NS = 4 * MAIN_CLK_NS;
  localparam int REJECT_CYC = (REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    TPG_IDLE = 2'b00,
    TPG_ARMED = 2'b01,
    TPG_RUN = 2'b10
  } tpg_state_t;

endpackage : tpg_pkg

// >>> tpg_pulse_mon.sv
/*
 Load on the pulse pin: measures the last complete low and high widths.
 Assumes the pin is sampled on the system clock.
*/
`timescale 1ns/1ps
module tpg_pulse_mon (
  // Clock
  input wire logic clk_i,
  // Observed pin, active low
  input wire logic pin_n_i,
  // Widths in clock cycles
  output int low_w_o,
  output int high_w_o
);
  int run;
  logic last;
  // Passive receiver: never drives the pin back
  always @(posedge clk_i) begin
    if (pin_n_i !== last) begin
      if (last === 1'b1) high_w_o <= run;
      else if (last === 1'b0) low_w_o <= run;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    last <= pin_n_i;
  end
endmodule : tpg_pulse_mon

// >>> tpg_timer.sv
/*
 Programmable pulse generator: 16-bit up-counter compared with a period and a
 duty register, toggling an output flip-flop that drives an active-low pin.
 Assumes an APB master for software access and a downstream interrupt
 controller that takes a one-cycle request.
*/
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - start by command or pin edge
// - repeat bit: 0 continuous, 1 one-shot
// - duty match toggles output, interrupts, counts
// - period match toggles, interrupts, clears counter
// - stopping holds the pulse pin level
// - one-shot period match clears start, stops
// - pin is inverse of output flip-flop
// - reset clears output flip-flop
// - level write after inverted stop inverts
// - timer-mode write reinitialises output flip-flop
// - input pin rejects short noise pulses
module tpg_timer #(
  parameter int CNT_W = 16,
  parameter int FILT_CYC = tpg_pkg::REJECT_CYC + 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pin side
  input wire logic timer_input_pin_i,
  output logic pulse_out_n_o,
  output logic timer_interrupt_o
);
  import tpg_pkg::*;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  logic [2:0] mode_q;
  logic [2:0] mode_d;
  logic [1:0] start_q;
  logic [1:0] start_d;
  logic repeat_q;
  logic repeat_d;
  logic [1:0] presc_q;
  logic [1:0] presc_d;
  logic level_q;
  logic level_d;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] period_d;
  logic [CNT_W-1:0] duty_q;
  logic [CNT_W-1:0] duty_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic ff_q;
  logic ff_d;
  logic ff_eng;
  logic self_stop;
  logic pout_n_q;
  logic pout_n_d;
  logic irq_q;
  logic irq_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rdy_q;
  logic rdy_d;
  logic err_q;
  logic err_d;
  tpg_state_t state_q;
  tpg_state_t state_d;

  logic acc;
  logic wr;
  logic ctrl_wr;
  logic tick;
  logic trig;
  logic [31:0] ctrl_word;

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning

  tpg_in_filter #(
    .HOLD_CYC(FILT_CYC)
  ) u_filter (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(timer_input_pin_i),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: the answer is prepared in the first access cycle and pready
  // rises one cycle later; a write lands only at the edge that samples pready
  // high, so the write and the end of the transfer fall on one edge

  assign acc = psel_i && penable_i && !rdy_q;
  assign wr = psel_i && penable_i && pwrite_i && rdy_q;
  assign ctrl_wr = wr && (paddr_i == CTRL_OFF) && pstrb_i[0] && pstrb_i[1];

  assign ctrl_word = {23'h0, level_q, presc_q, repeat_q, start_q, mode_q};

  ////////////////////////////////////////////////////////////////////////////
  // Source clock: divide by 1, 2, 4 or 8 from the prescaler field

  assign tick = (presc_q == 2'h0) ? 1'b1 : (div_q[2:0] & ((3'h1 << presc_q) - 3'h1)) == 3'h0;

  assign trig = (start_q == START_CMD) || (start_q == START_RISE && pin_rise)
    || (start_q == START_FALL && pin_fall);

  ////////////////////////////////////////////////////////////////////////////
  // Counting engine: only proposes the toggle and the one-shot stop; the
  // register group decides, so a software write can still win

  always_comb begin
    cnt_d = cnt_q;
    ff_eng = ff_q;
    irq_d = 1'b0;
    self_stop = 1'b0;
    state_d = state_q;
    div_d = (state_q == TPG_RUN) ? div_q + 3'h1 : 3'h0;
    unique case (state_q)
      TPG_IDLE: begin
        if (mode_q == MODE_PULSE && start_q != START_STOP) begin
          state_d = TPG_ARMED;
        end
      end
      TPG_ARMED: begin
        if (start_q == START_STOP || mode_q != MODE_PULSE) begin
          state_d = TPG_IDLE;
        end else if (trig) begin
          state_d = TPG_RUN;
          cnt_d = '0;
        end
      end
      TPG_RUN: begin
        if (start_q == START_STOP || mode_q != MODE_PULSE) begin
          state_d = TPG_IDLE;
        end else if (tick) begin
          if (cnt_q == period_q) begin
            ff_eng = !ff_q;
            irq_d = 1'b1;
            cnt_d = '0;
            if (repeat_q) begin
              self_stop = 1'b1;
              state_d = TPG_IDLE;
            end
          end else begin
            if (cnt_q == duty_q) begin
              ff_eng = !ff_q;
              irq_d = 1'b1;
            end
            cnt_d = cnt_q + CNT_W'(1);
          end
        end
      end
      default: state_d = TPG_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and compare registers

  always_comb begin
    mode_d = mode_q;
    start_d = start_q;
    repeat_d = repeat_q;
    presc_d = presc_q;
    level_d = level_q;
    period_d = period_q;
    duty_d = duty_q;
    ff_d = ff_eng;
    if (self_stop) begin
      start_d = START_STOP;
    end

    // Software writes win over the engine's own clear of the start field
    if (ctrl_wr) begin
      mode_d = pwdata_i[MODE_LSB +: MODE_W];
      start_d = pwdata_i[START_LSB +: START_W];
      repeat_d = pwdata_i[REPEAT_BIT];
      presc_d = pwdata_i[PRESC_LSB +: PRESC_W];
      level_d = pwdata_i[LEVEL_BIT];
      if (pwdata_i[MODE_LSB +: MODE_W] == MODE_TIMER) begin
        ff_d = 1'b0;
      end else if (pwdata_i[LEVEL_BIT] != level_q && state_q != TPG_RUN) begin
        // Level field acts as toggle on change; after an inverted stop
        // the flip-flop ends at the inverse of the written value
        ff_d = !ff_q;
      end
    end
    if (wr && paddr_i == PERIOD_OFF) begin
      period_d = pwdata_i[CNT_W-1:0];
    end
    if (wr && paddr_i == DUTY_OFF) begin
      duty_d = pwdata_i[CNT_W-1:0];
    end
    // Pin register follows the flip-flop in the same cycle
    pout_n_d = !ff_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer

  always_comb begin
    rdy_d = psel_i && penable_i && !rdy_q;
    err_d = 1'b0;
    rdata_d = 32'h0;
    if (acc) begin
      unique case (paddr_i)
        CTRL_OFF: rdata_d = ctrl_word;
        PERIOD_OFF: rdata_d = {16'h0, period_q};
        DUTY_OFF: rdata_d = {16'h0, duty_q};
        COUNT_OFF: rdata_d = {16'h0, cnt_q};
        STAT_OFF: rdata_d = {28'h0, pin_level, ff_q, state_q};
        default: err_d = 1'b1;
      endcase
      if (pwrite_i && (paddr_i == COUNT_OFF || paddr_i == STAT_OFF)) begin
        err_d = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      div_q <= 3'h0;
      irq_q <= 1'b0;
      state_q <= TPG_IDLE;
    end else begin
      cnt_q <= cnt_d;
      div_q <= div_d;
      irq_q <= irq_d;
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_TIMER;
      start_q <= START_STOP;
      repeat_q <= 1'b0;
      presc_q <= 2'h0;
      level_q <= 1'b0;
      period_q <= PERIOD_RST;
      duty_q <= DUTY_RST;
      ff_q <= 1'b0;
      pout_n_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      start_q <= start_d;
      repeat_q <= repeat_d;
      presc_q <= presc_d;
      level_q <= level_d;
      period_q <= period_d;
      duty_q <= duty_d;
      ff_q <= ff_d;
      pout_n_q <= pout_n_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pulse_out_n_o = pout_n_q;
  assign timer_interrupt_o = irq_q;
  assign prdata_o = rdata_q;
  assign pready_o = rdy_q;
  assign pslverr_o = err_q;

endmodule : tpg_timer

// >>> tpg_timer_properties.sv
/*
 Port checker for the pulse-generation timer.
 Assumes byte strobes are all set on every access.
*/
`timescale 1ns/1ps
module tpg_timer_properties
  import tpg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pin side
  input wire logic pulse_out_n_o,
  input wire logic timer_interrupt_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_done;
    psel_i && penable_i && pready_o;
  endsequence
  property p_rst_out;
    $fell(rst_i) |-> pulse_out_n_o && !timer_interrupt_o && !pready_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_rdy_lat;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("late ready");
  property p_rdy_one;
    pready_o |=> !pready_o;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready held");
  property p_ro_err;
    s_done ##0 (pwrite_i && paddr_i == COUNT_OFF) |-> pslverr_o;
  endproperty
  a_ro_err: assert property (p_ro_err) else $error("count write accepted");
  property p_map_err;
    s_done ##0 (paddr_i > STAT_OFF) |-> pslverr_o;
  endproperty
  a_map_err: assert property (p_map_err) else $error("unmapped access accepted");
  property p_ctrl_ok;
    s_done ##0 (paddr_i == CTRL_OFF) |-> !pslverr_o;
  endproperty
  a_ctrl_ok: assert property (p_ctrl_ok) else $error("control access refused");
  property p_rd_hi;
    s_done ##0 (!pwrite_i && paddr_i == PERIOD_OFF) |-> prdata_o[31:16] == 16'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("period upper bits set");
  property p_irq_one;
    timer_interrupt_o |=> !timer_interrupt_o;
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("interrupt longer than one cycle");
  property p_tmr_clr;
    s_done ##0 (pwrite_i && paddr_i == CTRL_OFF && pwdata_i[8:0] == 9'h0) |-> ##[0:2] pulse_out_n_o;
  endproperty
  a_tmr_clr: assert property (p_tmr_clr) else $error("timer mode left pin low");
endmodule : tpg_timer_properties

bind tpg_timer tpg_timer_properties chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .pulse_out_n_o(pulse_out_n_o), .timer_interrupt_o(timer_interrupt_o));

// >>> tpg_timer_tb_top.sv
/*
 Self-checking bench for the pulse-generation timer.
 Assumes the pulse monitor and the bound port checker.
*/
`timescale 1ns/1ps
module tpg_timer_tb_top;
  import tpg_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pin, pready, pslverr, pout_n, irq, err, keep;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dv, pv;
  int n_fail, num_checks, n_irq, irq_base, low_w, high_w;
  tpg_timer dut_u (.ref_clk_i(ref_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .timer_input_pin_i(pin),
    .pulse_out_n_o(pout_n), .timer_interrupt_o(irq));
  tpg_pulse_mon mon_u (.clk_i(ref_clk), .pin_n_i(pout_n), .low_w_o(low_w), .high_w_o(high_w));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (irq === 1'b1) n_irq <= n_irq + 1;
  function automatic logic [31:0] ctl(input logic lv, input logic rep, input logic [1:0] st);
    return {23'h0, lv, 2'h0, rep, st, MODE_PULSE};
  endfunction : ctl
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (6000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, pin} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst = 1'b1;
    void'($urandom(78230));
    idle(20);
    rst <= 1'b0;
    idle(1);
    chk("reset pin", pout_n, 1);
    apb(0, PERIOD_OFF, 0);
    chk("period reset", rd, {16'h0, PERIOD_RST});
    apb(0, 8'h14, 0);
    chk("unmapped", err, 1);
    apb(1, COUNT_OFF, 32'h5);
    chk("count write", err, 1);
    apb(1, CTRL_OFF, 0);
    apb(1, CTRL_OFF, ctl(1, 0, START_STOP));
    idle(3);
    chk("initial level", pout_n, 0);
    dv = 16'(2 + $urandom % 20);
    pv = dv + 16'(2 + $urandom % 20);
    apb(1, PERIOD_OFF, {16'h0, pv});
    apb(1, DUTY_OFF, {16'h0, dv});
    apb(1, CTRL_OFF, ctl(1, 0, START_CMD));
    idle(4 * pv + 20);
    chk("high width", 32'(high_w), 32'(pv - dv));
    chk("low width", 32'(low_w), 32'(dv + 1));
    apb(1, CTRL_OFF, ctl(1, 0, START_STOP));
    idle(3);
    keep = pout_n;
    irq_base = n_irq;
    idle(3 * pv);
    chk("held level", pout_n, keep);
    chk("stopped irq", n_irq - irq_base, 0);
    apb(1, CTRL_OFF, ctl(0, 0, START_STOP));
    idle(3);
    chk("level rewrite", pout_n, !keep);
    apb(1, CTRL_OFF, 0);
    apb(1, CTRL_OFF, ctl(1, 1, START_STOP));
    irq_base = n_irq;
    apb(1, CTRL_OFF, ctl(1, 1, START_CMD));
    idle(3 * pv + 20);
    chk("one-shot irqs", n_irq - irq_base, 2);
    chk("one-shot pin", pout_n, 0);
    apb(0, CTRL_OFF, 0);
    chk("start cleared", rd[4:3], START_STOP);
    // Divide-by-8 source clock: each compare step lasts eight cycles
    apb(1, CTRL_OFF, ctl(1, 1, START_CMD) | (32'h3 << PRESC_LSB));
    idle(8 * pv + 40);
    chk("prescaled width", 32'(high_w), 32'(8 * (pv - dv)));
    apb(1, CTRL_OFF, ctl(1, 1, START_RISE));
    irq_base = n_irq;
    pin <= 1'b1;
    idle(REJECT_CYC);
    pin <= 1'b0;
    idle(30);
    chk("glitch start", n_irq - irq_base, 0);
    pin <= 1'b1;
    idle(3 * pv + 40);
    chk("edge start", n_irq - irq_base, 2);
    apb(1, CTRL_OFF, ctl(1, 1, START_FALL));
    irq_base = n_irq;
    pin <= 1'b0;
    idle(3 * pv + 40);
    chk("fall start", n_irq - irq_base, 2);
    final_report();
  end
endmodule : tpg_timer_tb_top
